// >>> usbcp_cfg.svh
// Constants of the command-port controller
`ifndef USBCP_CFG_SVH
`define USBCP_CFG_SVH
`define USBCP_CMD_SEL 3'h4
`define USBCP_IFCFG_REG 6'h01
`define USBCP_DESC_REG 6'h30
`define USBCP_BUF_REG 6'h31
`define USBCP_SETUP_REG 6'h32
`define USBCP_COUNT_REG 6'h33
`define USBCP_XLO_REG 6'h3A
`define USBCP_XHI_REG 6'h3B
`define USBCP_XVAL_REG 6'h3C
`define USBCP_CHIRP_ADDR 16'hE6FB
`define USBCP_FULL_SPEED 8'h02
`define USBCP_DEFAULT_LEN 16'h0006
`define USBCP_OFF_CMD 8'h00
`define USBCP_OFF_WDATA 8'h04
`define USBCP_OFF_LEN 8'h08
`define USBCP_OFF_XADDR 8'h0C
`define USBCP_OFF_STATUS 8'h10
`define USBCP_OFF_RDATA 8'h14
`define USBCP_CMD_OP_LSB 8
`define USBCP_ST_BUSY 0
`define USBCP_ST_DONE 1
`define USBCP_ST_REFUSED 2
`define USBCP_ST_READY 3
`define USBCP_ST_INT 4
`define USBCP_CLK_NS 10
`define USBCP_GAP_NS 20
`define USBCP_GAP_CYC ((`USBCP_GAP_NS + `USBCP_CLK_NS - 1) / `USBCP_CLK_NS)
`define USBCP_RESP_OKAY 2'h0
`define USBCP_RESP_SLVERR 2'h2
`endif

// >>> usbcp_pkg.sv
// Types of the command-port controller
package usbcp_pkg;
  typedef struct packed {
    logic [2:0] fifo_select_address;
    logic [7:0] data_out;
    logic data_oe;
    logic wr_n;
    logic rd_n;
    logic oe_n;
    logic commit_n;
    logic cs_n;
  } usbcp_pins_out_type;
  typedef struct packed {
    logic [7:0] data_in;
    logic ready;
    logic int_n;
  } usbcp_pins_in_type;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
  } usbcp_regwr_type;
  typedef enum logic [2:0] {OP_REG_WR, OP_REG_RD, OP_DATA, OP_DESC, OP_XWR, OP_XRD} usbcp_op_type;
  typedef enum logic [1:0] {KIND_NONE, KIND_WR, KIND_RD} usbcp_kind_type;
  typedef struct packed {
    usbcp_kind_type kind;
    logic is_addr;
    logic [7:0] tx_byte;
  } usbcp_step_type;
  typedef enum logic [2:0] {
    PIN_IDLE, PIN_WAIT_RDY, PIN_STROBE, PIN_SETTLE, PIN_WAIT_INT, PIN_OE, PIN_SAMPLE
  } usbcp_pin_state_type;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} usbcp_seq_state_type;
  typedef struct packed {
    usbcp_pin_state_type st;
    logic [2:0] cnt;
    logic wr;
    logic rd;
    logic oe;
    logic data_oe;
    logic [7:0] data_out;
    logic [7:0] rdata;
    logic done;
  } usbcp_pin_regs_type;
  typedef struct packed {
    logic aw_ok;
    logic [7:0] aw_addr;
    logic w_ok;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } usbcp_axil_regs_type;
  typedef struct packed {
    usbcp_seq_state_type st;
    usbcp_op_type op;
    logic [3:0] step;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [15:0] len;
    logic [15:0] xaddr;
    logic [7:0] rdata;
    logic done;
    logic refused;
  } usbcp_ctrl_regs_type;
endpackage

// >>> usbcp_pinif.sv
// Pin driver that moves one command byte over the device pins
`timescale 1ns/1ps
`default_nettype none
`include "usbcp_cfg.svh"
module usbcp_pinif (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic [7:0] req_byte,
  output logic req_ready,
  output logic done,
  output logic [7:0] rdata,
  input wire usbcp_pkg::usbcp_pins_in_type pins_in,
  output usbcp_pkg::usbcp_pins_out_type pins_out
);
  usbcp_pkg::usbcp_pin_regs_type s;
  usbcp_pkg::usbcp_pin_regs_type next_s;

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.wr = 1'b0;
    next_s.rd = 1'b0;
    case (s.st)
      usbcp_pkg::PIN_IDLE:
        if (req_valid)
        begin
          next_s.data_out = req_byte;
          next_s.data_oe = !req_read;
          next_s.st = req_read ? usbcp_pkg::PIN_WAIT_INT : usbcp_pkg::PIN_WAIT_RDY;
        end
      usbcp_pkg::PIN_WAIT_RDY:
        if (pins_in.ready)
        begin
          next_s.wr = 1'b1;
          next_s.st = usbcp_pkg::PIN_STROBE;
        end
      usbcp_pkg::PIN_STROBE:
      begin
        next_s.data_oe = 1'b0;
        next_s.cnt = 3'(`USBCP_GAP_CYC);
        next_s.st = usbcp_pkg::PIN_SETTLE;
      end
      usbcp_pkg::PIN_SETTLE:
        if (s.cnt <= 3'h1)
        begin
          next_s.done = 1'b1;
          next_s.st = usbcp_pkg::PIN_IDLE;
        end
        else
          next_s.cnt = 3'(s.cnt - 3'h1);
      usbcp_pkg::PIN_WAIT_INT:
        if (!pins_in.int_n)
        begin
          next_s.oe = 1'b1;
          next_s.st = usbcp_pkg::PIN_OE;
        end
      usbcp_pkg::PIN_OE:
      begin
        next_s.rd = 1'b1;
        next_s.st = usbcp_pkg::PIN_SAMPLE;
      end
      usbcp_pkg::PIN_SAMPLE:
      begin
        next_s.rdata = pins_in.data_in;
        next_s.oe = 1'b0;
        next_s.cnt = 3'(`USBCP_GAP_CYC);
        next_s.st = usbcp_pkg::PIN_SETTLE;
      end
      default:
        next_s = '0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign req_ready = (s.st == usbcp_pkg::PIN_IDLE);
  assign done = s.done;
  assign rdata = s.rdata;
  assign pins_out.fifo_select_address = `USBCP_CMD_SEL;
  assign pins_out.data_out = s.data_out;
  assign pins_out.data_oe = s.data_oe;
  assign pins_out.wr_n = !s.wr;
  assign pins_out.rd_n = !s.rd;
  assign pins_out.oe_n = !s.oe;
  assign pins_out.commit_n = 1'b1;
  assign pins_out.cs_n = 1'b0;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_STROBE_READY: assert property (!pins_out.wr_n |-> $past(pins_in.ready))
    else $error("Strobe without ready");
  AST_STROBE_ONE: assert property (!pins_out.wr_n |=> pins_out.wr_n && !pins_out.data_oe)
    else $error("Strobe longer than one cycle");
  AST_RD_OE: assert property (!pins_out.rd_n |-> !pins_out.oe_n && $past(!pins_out.oe_n))
    else $error("Read strobe without output enable");
endmodule
`default_nettype wire

// >>> usbcp_axil.sv
// AXI4-Lite slave front end for the controller registers
`timescale 1ns/1ps
`default_nettype none
`include "usbcp_cfg.svh"
module usbcp_axil (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output usbcp_pkg::usbcp_regwr_type regwr,
  input wire logic wr_ok,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  usbcp_pkg::usbcp_axil_regs_type s;
  usbcp_pkg::usbcp_axil_regs_type next_s;

  assign awready = !s.aw_ok;
  assign wready = !s.w_ok;
  assign arready = !s.rvalid;
  assign regwr.wr = s.aw_ok && s.w_ok && !s.bvalid;
  assign regwr.addr = s.aw_addr;
  assign regwr.wdata = s.w_data;
  assign regwr.strb = s.w_strb;

  always_comb
  begin
    next_s = s;
    if (awvalid && !s.aw_ok)
    begin
      next_s.aw_ok = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && !s.w_ok)
    begin
      next_s.w_ok = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.bvalid && bready)
      next_s.bvalid = 1'b0;
    if (regwr.wr)
    begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_ok ? `USBCP_RESP_OKAY : `USBCP_RESP_SLVERR;
    end
    if (s.rvalid && rready)
      next_s.rvalid = 1'b0;
    if (arvalid && !s.rvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_data;
      next_s.rresp = rd_ok ? `USBCP_RESP_OKAY : `USBCP_RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
endmodule
`default_nettype wire

// >>> usbcp_ctrl.sv
// Command-port controller top: register file, byte sequencer and checks
//
// Contract
// - Start commands only on command select with ready
// - Address byte: bit7 set, bit6 read, six-bit address
// - Data byte: bit7 clear, low nibble carries data
// - Upper nibble first, then lower; device stores byte
// - Descriptor load: one address, length low first
// - Descriptors supplied in fixed documented order
// - Full-speed value to chirp register before download
// - Length six selects default descriptor with IDs
// - Non-zero write to setup register stalls request
// - IN phase: buffer byte writes, then count
// - Commit strobe unused on control endpoint
// - OUT phase: read count, then buffer bytes
// - New setup re-signalled; zero count ends handshake
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "usbcp_cfg.svh"
module usbcp_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire usbcp_pkg::usbcp_pins_in_type pins_in,
  output usbcp_pkg::usbcp_pins_out_type pins_out
);
  usbcp_pkg::usbcp_ctrl_regs_type s;
  usbcp_pkg::usbcp_ctrl_regs_type next_s;
  usbcp_pkg::usbcp_regwr_type regwr;
  usbcp_pkg::usbcp_step_type step_i;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_data;
  logic pin_valid;
  logic pin_ready;
  logic pin_done;
  logic [7:0] pin_rdata;
  logic idle;
  logic take;
  logic [2:0] cmd_op;

  // Address byte with direction bit
  function automatic usbcp_pkg::usbcp_step_type usbcp_abyte(input logic rd, input logic [5:0] a);
    usbcp_pkg::usbcp_step_type r;
    r.kind = usbcp_pkg::KIND_WR;
    r.is_addr = 1'b1;
    r.tx_byte = {1'b1, rd, a};
    return r;
  endfunction

  // Data byte carrying one nibble
  function automatic usbcp_pkg::usbcp_step_type usbcp_nib(input logic [3:0] n);
    usbcp_pkg::usbcp_step_type r;
    r.kind = usbcp_pkg::KIND_WR;
    r.is_addr = 1'b0;
    r.tx_byte = {4'h0, n};
    return r;
  endfunction

  // Unindexed register address in two indexed writes
  function automatic usbcp_pkg::usbcp_step_type usbcp_xhdr(input logic [3:0] st,
                                                          input logic [15:0] xa);
    usbcp_pkg::usbcp_step_type r;
    case (st)
      4'h0: r = usbcp_abyte(1'b0, `USBCP_XLO_REG);
      4'h1: r = usbcp_nib(xa[7:4]);
      4'h2: r = usbcp_nib(xa[3:0]);
      4'h3: r = usbcp_abyte(1'b0, `USBCP_XHI_REG);
      4'h4: r = usbcp_nib(xa[15:12]);
      default: r = usbcp_nib(xa[11:8]);
    endcase
    return r;
  endfunction

  // Byte to send at a given step of an operation
  function automatic usbcp_pkg::usbcp_step_type usbcp_step(input usbcp_pkg::usbcp_op_type op,
                                                          input logic [3:0] st,
                                                          input logic [5:0] a,
                                                          input logic [7:0] wd,
                                                          input logic [15:0] len,
                                                          input logic [15:0] xa);
    usbcp_pkg::usbcp_step_type r;
    usbcp_pkg::usbcp_step_type rdb;
    r = '{kind: usbcp_pkg::KIND_NONE, is_addr: 1'b0, tx_byte: 8'h00};
    rdb = '{kind: usbcp_pkg::KIND_RD, is_addr: 1'b0, tx_byte: 8'h00};
    case (op)
      // Stall, buffer fill and count commits are plain register writes
      usbcp_pkg::OP_REG_WR:
        case (st)
          4'h0: r = usbcp_abyte(1'b0, a);
          4'h1: r = usbcp_nib(wd[7:4]);
          4'h2: r = usbcp_nib(wd[3:0]);
          default: r = r;
        endcase
      usbcp_pkg::OP_REG_RD:
        case (st)
          4'h0: r = usbcp_abyte(1'b1, a);
          4'h1: r = rdb;
          default: r = r;
        endcase
      // Stream byte with no address, sent in the order software gives
      usbcp_pkg::OP_DATA:
        case (st)
          4'h0: r = usbcp_nib(wd[7:4]);
          4'h1: r = usbcp_nib(wd[3:0]);
          default: r = r;
        endcase
      usbcp_pkg::OP_DESC:
        case (st)
          4'h0: r = usbcp_abyte(1'b0, `USBCP_DESC_REG);
          4'h1: r = usbcp_nib(len[7:4]);
          4'h2: r = usbcp_nib(len[3:0]);
          4'h3: r = usbcp_nib(len[15:12]);
          4'h4: r = usbcp_nib(len[11:8]);
          default: r = r;
        endcase
      usbcp_pkg::OP_XWR:
        if (st < 4'h6)
          r = usbcp_xhdr(st, xa);
        else if (st == 4'h6)
          r = usbcp_abyte(1'b0, `USBCP_XVAL_REG);
        else if (st == 4'h7)
          r = usbcp_nib(wd[7:4]);
        else if (st == 4'h8)
          r = usbcp_nib(wd[3:0]);
      usbcp_pkg::OP_XRD:
        if (st < 4'h6)
          r = usbcp_xhdr(st, xa);
        else if (st == 4'h6)
          r = usbcp_abyte(1'b1, `USBCP_XVAL_REG);
        else if (st == 4'h7)
          r = rdb;
      default: r = r;
    endcase
    return r;
  endfunction

  // Byte-lane merge of a bus write
  function automatic logic [31:0] usbcp_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  usbcp_axil u_axil (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .regwr(regwr),
    .wr_ok(wr_ok),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  usbcp_pinif u_pinif (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .req_valid(pin_valid),
    .req_read(step_i.kind == usbcp_pkg::KIND_RD),
    .req_byte(step_i.tx_byte),
    .req_ready(pin_ready),
    .done(pin_done),
    .rdata(pin_rdata),
    .pins_in(pins_in),
    .pins_out(pins_out)
  );

  assign step_i = usbcp_step(s.op, s.step, s.addr, s.wdata, s.len, s.xaddr);
  assign idle = (s.st == usbcp_pkg::SEQ_IDLE);
  assign take = pin_valid && pin_ready;
  assign cmd_op = regwr.wdata[`USBCP_CMD_OP_LSB +: 3];
  assign wr_ok = (regwr.addr == `USBCP_OFF_CMD) || (regwr.addr == `USBCP_OFF_WDATA) ||
                 (regwr.addr == `USBCP_OFF_LEN) || (regwr.addr == `USBCP_OFF_XADDR);

  // Register read mux
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    case (araddr)
      `USBCP_OFF_CMD: rd_data = 32'h0000_0000;
      `USBCP_OFF_WDATA: rd_data = {24'h00_0000, s.wdata};
      `USBCP_OFF_LEN: rd_data = {16'h0000, s.len};
      `USBCP_OFF_XADDR: rd_data = {16'h0000, s.xaddr};
      `USBCP_OFF_STATUS:
      begin
        rd_data[`USBCP_ST_BUSY] = !idle;
        rd_data[`USBCP_ST_DONE] = s.done;
        rd_data[`USBCP_ST_REFUSED] = s.refused;
        rd_data[`USBCP_ST_READY] = pins_in.ready;
        rd_data[`USBCP_ST_INT] = !pins_in.int_n;
      end
      `USBCP_OFF_RDATA: rd_data = {24'h00_0000, s.rdata};
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    next_s = s;
    pin_valid = 1'b0;
    if (regwr.wr)
    begin
      if (!idle)
        next_s.refused = 1'b1;
      else if (regwr.addr == `USBCP_OFF_WDATA)
        next_s.wdata = 8'(usbcp_merge({24'h00_0000, s.wdata}, regwr.wdata, regwr.strb));
      else if (regwr.addr == `USBCP_OFF_LEN)
        next_s.len = 16'(usbcp_merge({16'h0000, s.len}, regwr.wdata, regwr.strb));
      else if (regwr.addr == `USBCP_OFF_XADDR)
        next_s.xaddr = 16'(usbcp_merge({16'h0000, s.xaddr}, regwr.wdata, regwr.strb));
      else if (regwr.addr == `USBCP_OFF_CMD)
      begin
        if (cmd_op <= 3'h5 && regwr.strb[1:0] == 2'h3)
        begin
          next_s.op = usbcp_pkg::usbcp_op_type'(cmd_op);
          next_s.addr = regwr.wdata[5:0];
          next_s.step = 4'h0;
          next_s.done = 1'b0;
          next_s.refused = 1'b0;
          next_s.st = usbcp_pkg::SEQ_ISSUE;
        end
        else
          next_s.refused = 1'b1;
      end
    end
    case (s.st)
      usbcp_pkg::SEQ_IDLE:
        next_s.st = next_s.st;
      usbcp_pkg::SEQ_ISSUE:
        if (step_i.kind == usbcp_pkg::KIND_NONE)
        begin
          next_s.done = 1'b1;
          next_s.st = usbcp_pkg::SEQ_IDLE;
        end
        else
        begin
          pin_valid = 1'b1;
          if (pin_ready)
            next_s.st = usbcp_pkg::SEQ_WAIT;
        end
      usbcp_pkg::SEQ_WAIT:
        if (pin_done)
        begin
          next_s.rdata = pin_rdata;
          next_s.step = 4'(s.step + 4'h1);
          next_s.st = usbcp_pkg::SEQ_ISSUE;
        end
      default:
        next_s.st = usbcp_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.wdata <= `USBCP_FULL_SPEED;
      s.len <= `USBCP_DEFAULT_LEN;
      s.xaddr <= `USBCP_CHIRP_ADDR;
    end
    else
      s <= next_s;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_WR_ADDR: assert property (take && s.op == usbcp_pkg::OP_REG_WR && s.step == 4'h0
    |-> step_i.tx_byte == {2'h2, s.addr})
    else $error("Bad write address byte");
  AST_RD_ADDR: assert property (take && s.op == usbcp_pkg::OP_REG_RD && s.step == 4'h0
    |-> step_i.tx_byte == {2'h3, s.addr})
    else $error("Bad read address byte");
  AST_NIB_FMT: assert property (take && !step_i.is_addr && step_i.kind == usbcp_pkg::KIND_WR
    |-> step_i.tx_byte[7:4] == 4'h0)
    else $error("Data byte has upper bits set");
  AST_HI_FIRST: assert property (take && s.op == usbcp_pkg::OP_REG_WR && s.step == 4'h1
    |-> step_i.tx_byte[3:0] == s.wdata[7:4])
    else $error("Upper nibble not sent first");
  AST_DESC_ADDR: assert property (take && s.op == usbcp_pkg::OP_DESC && s.step == 4'h0
    |-> step_i.tx_byte == {2'h2, `USBCP_DESC_REG})
    else $error("Descriptor load not at descriptor register");
  AST_DESC_LEN: assert property (take && s.op == usbcp_pkg::OP_DESC && s.step == 4'h1
    |-> step_i.tx_byte[3:0] == s.len[7:4])
    else $error("Length low byte not first");
  AST_XVAL: assert property (take && s.op == usbcp_pkg::OP_XWR && s.step == 4'h6
    |-> step_i.tx_byte == {2'h2, `USBCP_XVAL_REG})
    else $error("Unindexed value not at value register");
  AST_END: assert property (s.st == usbcp_pkg::SEQ_ISSUE && step_i.kind == usbcp_pkg::KIND_NONE
    |=> s.done && idle)
    else $error("Operation end not flagged");
  AST_REFUSE: assert property (regwr.wr && !idle |=> s.refused)
    else $error("Busy command not refused");
  AST_WAIT_PIN: assert property (s.st == usbcp_pkg::SEQ_WAIT && !pin_done |-> !pin_ready)
    else $error("Pin driver idle while byte pending");
  COV_REG_WR: cover property (s.op == usbcp_pkg::OP_REG_WR && s.st == usbcp_pkg::SEQ_ISSUE
    && step_i.kind == usbcp_pkg::KIND_NONE);
  COV_REG_RD: cover property (s.op == usbcp_pkg::OP_REG_RD && pin_done);
  COV_XWR: cover property (s.op == usbcp_pkg::OP_XWR && s.step == 4'h9);
  COV_DESC: cover property (s.op == usbcp_pkg::OP_DESC && s.step == 4'h5);
endmodule
`default_nettype wire

// >>> usbcp_dev_model.sv
// Behavioural model of the device command port
`timescale 1ns/1ps
`default_nettype none
module usbcp_dev_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire usbcp_pkg::usbcp_pins_out_type po,
  output var usbcp_pkg::usbcp_pins_in_type pi
);
  logic [7:0] regs [64];
  logic [7:0] setup [8];
  logic [7:0] rdv, v;
  logic [15:0] dlen;
  logic [5:0] a;
  logic [3:0] hi, busy, dn;
  logic [2:0] sidx;
  logic hi_ok, rd_pend, stall, ready, int_n, dflt;
  logic enum_done, setup_evt, buf_evt;
  logic [15:0] in_cnt;
  // Released bus shows the inverse of the last value
  assign pi = {(po.oe_n ? ~rdv : rdv), ready, int_n};
  assign dflt = dlen == 16'h0006 && dn == 4'h8;
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      {ready, hi_ok, rd_pend, stall, enum_done, buf_evt, sidx, dn, rdv, dlen, in_cnt} <= '0;
      setup_evt <= 1'b1;
      {int_n, busy} <= 5'h13;
      for (int i = 0; i < 64; i++)
        regs[i] <= 8'h00;
      for (int i = 0; i < 8; i++)
        setup[i] <= 8'(8'h80 + 8'h13 * i);
    end
    else
    begin
      if (busy != 4'h0)
        busy <= busy - 4'h1;
      if (busy == 4'h1)
        ready <= 1'b1;
      if (busy == 4'h1 && rd_pend)
      begin
        int_n <= 1'b0;
        rdv <= (a == 6'h32) ? setup[sidx] : regs[a];
        sidx <= sidx + 3'(a == 6'h32);
        if (a == 6'h32)
        begin
          setup_evt <= 1'b0;
          buf_evt <= sidx == 3'h7 && {setup[7], setup[6]} != 16'h0000;
        end
      end
      if (!po.rd_n)
        {int_n, rd_pend} <= 2'h2;
      if (!po.wr_n && !po.cs_n && po.oe_n && po.data_oe
          && po.fifo_select_address == 3'h4)
      begin
        ready <= 1'b0;
        busy <= 4'(1 + $urandom % 8);
        v = {hi, po.data_out[3:0]};
        hi_ok <= !po.data_out[7] && !hi_ok;
        if (po.data_out[7])
        begin
          a <= po.data_out[5:0];
          dn <= 4'h0;
          rd_pend <= po.data_out[6];
        end
        if (!po.data_out[7] && !hi_ok)
          hi <= po.data_out[3:0];
        if (!po.data_out[7] && hi_ok)
        begin
          regs[a] <= v;
          dn <= dn + 4'h1;
          if (a == 6'h30 && dn < 4'h2)
            dlen <= {v, dlen[15:8]};
          if (a == 6'h32)
            stall <= v != 8'h00;
          if (a == 6'h31 && in_cnt < {setup[7], setup[6]})
            in_cnt <= in_cnt + 16'h0001;
          if (a == 6'h30 && dn > 4'h1 && {12'h000, dn} == dlen + 16'h0001)
            enum_done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> usbcp_ctrl_tb.sv
// Self-checking bench of the command-port controller
`timescale 1ns/1ps
`default_nettype none
module usbcp_ctrl_tb;
  logic sys_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [5:0] a;
  usbcp_pkg::usbcp_pins_in_type pins_in;
  usbcp_pkg::usbcp_pins_out_type pins_out;
  int n_fail, comparisons;
  usbcp_ctrl usbcp_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pins_in(pins_in), .pins_out(pins_out));
  usbcp_dev_model usbcp_dev_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .po(pins_out),
    .pi(pins_in));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic axw(input logic [7:0] ad, input logic [31:0] dt);
    awaddr <= ad;
    wdata <= dt;
    {awvalid, wvalid} <= 2'h3;
    do
    begin
      @(posedge sys_clk);
      if (awready && awvalid)
        awvalid <= 1'b0;
      if (wready && wvalid)
        wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask
  task automatic axr(input logic [7:0] ad);
    araddr <= ad;
    arvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arready && arvalid)
        arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task automatic op(input logic [2:0] o, input logic [5:0] ad);
    axw(8'h00, {21'h0, o, 2'h0, ad});
    d = 32'h0;
    while (d[1] !== 1'b1)
      axr(8'h10);
  endtask
  task automatic complete_run;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end
  initial
  begin
    {rst_n, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready, wstrb} = 6'h3F;
    n_fail = 0;
    comparisons = 0;
    v = $urandom(32'h007A7EA8);
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    axr(8'h08);
    chk("len_reset", 32'h6, d);
    chk("commit_idle", 32'h1, 32'(pins_out.commit_n));
    axr(8'h40);
    chk("unmapped_resp", 32'h2, 32'(r));
    axw(8'h14, 32'h0);
    chk("ro_write_resp", 32'h2, 32'(r));
    op(3'h4, 6'h00);
    chk("xaddr_low", 32'hFB, 32'(usbcp_dev_model_inst.regs[6'h3A]));
    chk("xaddr_high", 32'hE6, 32'(usbcp_dev_model_inst.regs[6'h3B]));
    chk("full_speed", 32'h2, 32'(usbcp_dev_model_inst.regs[6'h3C]));
    $display("test reset_and_chirp done");
    for (int i = 0; i < 5; i++)
    begin
      a = (i == 0) ? 6'h01 : 6'($urandom_range(47, 2));
      v = (i == 0) ? 32'hB0 : $urandom % 32'h100;
      axw(8'h04, v);
      op(3'h0, a);
      chk("reg_write", v, 32'(usbcp_dev_model_inst.regs[a]));
      op(3'h1, a);
      axr(8'h14);
      chk("reg_read", v, d);
    end
    $display("test reg_access done");
    chk("setup_pending", 32'h1, 32'(usbcp_dev_model_inst.setup_evt));
    for (int i = 0; i < 8; i++)
    begin
      op(3'h1, 6'h32);
      axr(8'h14);
      chk("setup_byte", 32'(usbcp_dev_model_inst.setup[i]), d);
    end
    chk("buffer_event", 32'h1, 32'(usbcp_dev_model_inst.buf_evt));
    chk("setup_taken", 32'h0, 32'(usbcp_dev_model_inst.setup_evt));
    axw(8'h04, 32'h5A);
    op(3'h0, 6'h31);
    chk("in_count", 32'h1, 32'(usbcp_dev_model_inst.in_cnt));
    axw(8'h04, 32'h1);
    op(3'h0, 6'h32);
    chk("stall", 32'h1, 32'(usbcp_dev_model_inst.stall));
    $display("test setup done");
    op(3'h3, 6'h30);
    for (int i = 0; i < 6; i++)
    begin
      v = $urandom % 32'h100;
      axw(8'h04, v);
      op(3'h2, 6'h00);
    end
    chk("desc_default", 32'h1, 32'(usbcp_dev_model_inst.dflt));
    chk("desc_last", v, 32'(usbcp_dev_model_inst.regs[6'h30]));
    chk("enum_done", 32'h1, 32'(usbcp_dev_model_inst.enum_done));
    axw(8'h00, 32'h600);
    axr(8'h10);
    chk("refused", 32'h1, 32'(d[2]));
    $display("test descriptor done");
    axw(8'h00, {21'h0, 3'h1, 2'h0, a});
    axw(8'h04, 32'hA5);
    axr(8'h10);
    chk("busy_flag", 32'h1, 32'(d[0]));
    chk("busy_refused", 32'h1, 32'(d[2]));
    while (d[1] !== 1'b1)
      axr(8'h10);
    axr(8'h04);
    chk("wdata_kept", v, d);
    $display("test busy_refusal done");
    complete_run();
  end
endmodule
`default_nettype wire
